/* File: design/dlpg_gate.sv */
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ps
module dlpg_gate (
	input  wire logic        clk_sys_i,
	input  wire logic        arst_n_i,
	// Register port
	input  wire logic [3:0]  reg_addr_i,
	input  wire logic [31:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [31:0] reg_rdata_o,
	// Debug port power-up requests (other domain)
	input  wire logic        dbg_pwrup_req_i,
	input  wire logic        sys_pwrup_req_i,
	// Power mode controller side
	input  wire logic [2:0]  mode_req_i,
	input  wire logic        recovery_i,
	input  wire logic [1:0]  security_state_i,
	input  wire logic [1:0]  mass_erase_enable_i,
	input  wire logic        core_halted_i,
	output logic [2:0]       mode_o,
	output logic             fast_core_clock_en_o,
	output logic             crossbar_block_o,
	output logic             debug_capture_en_o,
	output logic             debug_reset_o,
	output logic             sys_reset_hold_o,
	output logic             mass_erase_o,
	output logic             secured_o
);
	// Reset release
	logic [1:0] rst_sync_reg;
	logic       rst_n;

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	// Power-up requests cross from the debug port clock
	logic [1:0] pwr_sync;

	dlpg_sync #(.W(2)) u_pwr_sync (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n),
		.d_i       ({sys_pwrup_req_i, dbg_pwrup_req_i}),
		.q_o       (pwr_sync)
	);

	// Requests are assumed stable outside run and wait modes
	logic dbg_active;
	assign dbg_active = pwr_sync[0] | pwr_sync[1];

	// State registers
	dlpg_pkg::dlpg_mode_t mode_reg, mode_next;   // Granted mode
	logic [dlpg_pkg::CT_WIDTH-1:0] ctrl_reg;     // Control bits
	logic [dlpg_pkg::CT_WIDTH-1:0] ctrl_next;
	logic        leak_exit_reg, leak_exit_next;  // Leakage exit flag
	logic        vleak_exit_reg, vleak_exit_next; // Very leakage exit
	logic        pseudo_reg, pseudo_next;        // Substituted stop
	logic        clk_kept_reg, clk_kept_next;    // Clock held for debug
	logic        xbar_blk_reg, xbar_blk_next;    // Crossbar blocked
	logic        capt_reg, capt_next;            // Debug capture allowed
	logic        dbg_rst_reg, dbg_rst_next;      // Debug logic reset
	logic        hold_reg, hold_next;            // System held in reset
	logic        erase_reg, erase_next;          // Erase running
	logic        erase_ack_reg, erase_ack_next;  // Erase accepted
	logic [7:0]  erase_cnt_reg, erase_cnt_next;  // Erase timer
	logic        secured_reg, secured_next;      // Security state
	logic [31:0] rdata_reg, rdata_next;          // Read data
	logic [31:0] status_w;                       // Status word

	// Status word assembly, readable whether secured or not
	always_comb begin
		status_w = 32'h0;
		status_w[dlpg_pkg::ST_ERASE_ACK]   = erase_ack_reg;
		status_w[dlpg_pkg::ST_ERASE_BUSY]  = erase_reg;
		status_w[dlpg_pkg::ST_SECURE]      = secured_reg;
		status_w[dlpg_pkg::ST_ERASE_EN]    = !(secured_reg &&
			mass_erase_enable_i == dlpg_pkg::ERASE_OFF);
		status_w[dlpg_pkg::ST_PSEUDO_STOP] = pseudo_reg;
		status_w[dlpg_pkg::ST_CLK_KEPT]    = clk_kept_reg;
		status_w[dlpg_pkg::ST_VLP]         =
			(mode_reg == dlpg_pkg::PM_VLP_RUN)
			|| (mode_reg == dlpg_pkg::PM_VLP_WAIT);
		status_w[dlpg_pkg::ST_LEAK_EXIT]   = leak_exit_reg;
		status_w[dlpg_pkg::ST_VLEAK_EXIT]  = vleak_exit_reg;
		status_w[dlpg_pkg::ST_CORE_HALTED] = core_halted_i;
		status_w[dlpg_pkg::ST_SLEEPDEEP]   = mode_reg[2];
		status_w[dlpg_pkg::ST_SLEEPING]    = mode_reg[2] || mode_reg[1];
	end

	// Next state of the gate
	always_comb begin
		logic wr_ctl;
		logic ack;
		logic erase_try;
		wr_ctl = reg_wr_i && (reg_addr_i == dlpg_pkg::ADDR_CONTROL);
		ack = wr_ctl && reg_wdata_i[dlpg_pkg::CT_STAT_ACK];
		erase_try = wr_ctl && reg_wdata_i[dlpg_pkg::CT_ERASE_REQ];

		// Secured whenever the field is not the unsecure code
		secured_next = security_state_i != dlpg_pkg::SEC_UNSECURE;

		// Control write; secured state still accepts it
		ctrl_next = ctrl_reg;
		if (wr_ctl) begin
			ctrl_next = reg_wdata_i[dlpg_pkg::CT_WIDTH-1:0];
			ctrl_next[dlpg_pkg::CT_STAT_ACK] = 1'b0;
			ctrl_next[dlpg_pkg::CT_ERASE_REQ] = 1'b0;
		end

		// Mode grant with deep stop substitution
		mode_next = dlpg_pkg::dlpg_mode_t'(mode_req_i);
		pseudo_next = 1'b0;
		if (mode_req_i == dlpg_pkg::PM_VLP_STOP &&
			(ctrl_reg[dlpg_pkg::CT_DEBUG_EN] || dbg_active)) begin
			mode_next = dlpg_pkg::PM_STOP;
			pseudo_next = 1'b1;
		end

		// Keep fast clock in stop while debugger is active
		clk_kept_next = dbg_active && (mode_next == dlpg_pkg::PM_STOP);
		xbar_blk_next = clk_kept_next;

		// Capture only with the full debug port running
		capt_next = !(mode_next == dlpg_pkg::PM_LEAK_STOP ||
			mode_next == dlpg_pkg::PM_VLEAK_STOP) || clk_kept_next;
		if (mode_next == dlpg_pkg::PM_VLP_STOP) begin
			capt_next = 1'b0;
		end

		// Debug logic is reset only while very leakage stop lasts
		dbg_rst_next = (mode_reg == dlpg_pkg::PM_VLEAK_STOP);

		// Exit flags: set wins over acknowledge
		leak_exit_next = leak_exit_reg && !ack;
		vleak_exit_next = vleak_exit_reg && !ack;
		if (recovery_i && mode_reg == dlpg_pkg::PM_LEAK_STOP) begin
			leak_exit_next = 1'b1;
		end
		if (recovery_i && mode_reg == dlpg_pkg::PM_VLEAK_STOP) begin
			vleak_exit_next = 1'b1;
		end

		// Hold reset after very leakage recovery until released
		hold_next = hold_reg;
		if (recovery_i && mode_reg == dlpg_pkg::PM_VLEAK_STOP &&
			ctrl_reg[dlpg_pkg::CT_HOLD_RESET]) begin
			hold_next = 1'b1;
		end else if (!ctrl_reg[dlpg_pkg::CT_HOLD_RESET]) begin
			hold_next = 1'b0;
		end

		// Mass erase, blocked when secured and disabled
		erase_next = erase_reg;
		erase_ack_next = erase_ack_reg;
		erase_cnt_next = erase_cnt_reg;
		if (erase_reg) begin
			if (erase_cnt_reg == 8'h00) begin
				erase_next = 1'b0;
				erase_ack_next = 1'b0;
			end else begin
				erase_cnt_next = erase_cnt_reg - 8'h01;
			end
		end else if (erase_try && !(secured_reg &&
			mass_erase_enable_i == dlpg_pkg::ERASE_OFF)) begin
			erase_next = 1'b1;
			erase_ack_next = 1'b1;
			erase_cnt_next = dlpg_pkg::ERASE_CYCLES;
		end

		// Read data, one cycle later
		rdata_next = 32'h0;
		if (reg_rd_i) begin
			if (reg_addr_i == dlpg_pkg::ADDR_STATUS) begin
				rdata_next = status_w;
			end else if (reg_addr_i == dlpg_pkg::ADDR_CONTROL) begin
				rdata_next = {28'h0, ctrl_reg};
			end else if (reg_addr_i == dlpg_pkg::ADDR_MODE) begin
				rdata_next = {29'h0, mode_reg};
			end else begin
				rdata_next = 32'h0;
			end
		end
	end

	// Register all state
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			mode_reg      <= dlpg_pkg::PM_RUN;
			ctrl_reg      <= '0;
			leak_exit_reg  <= 1'b0;
			vleak_exit_reg <= 1'b0;
			pseudo_reg    <= 1'b0;
			clk_kept_reg  <= 1'b0;
			xbar_blk_reg  <= 1'b0;
			capt_reg      <= 1'b1;
			dbg_rst_reg   <= 1'b0;
			hold_reg      <= 1'b0;
			erase_reg     <= 1'b0;
			erase_ack_reg <= 1'b0;
			erase_cnt_reg <= 8'h00;
			secured_reg   <= 1'b1;
			rdata_reg     <= 32'h0;
		end else begin
			mode_reg      <= mode_next;
			ctrl_reg      <= ctrl_next;
			leak_exit_reg  <= leak_exit_next;
			vleak_exit_reg <= vleak_exit_next;
			pseudo_reg    <= pseudo_next;
			clk_kept_reg  <= clk_kept_next;
			xbar_blk_reg  <= xbar_blk_next;
			capt_reg      <= capt_next;
			dbg_rst_reg   <= dbg_rst_next;
			hold_reg      <= hold_next;
			erase_reg     <= erase_next;
			erase_ack_reg <= erase_ack_next;
			erase_cnt_reg <= erase_cnt_next;
			secured_reg   <= secured_next;
			rdata_reg     <= rdata_next;
		end
	end

	// Outputs straight from flops
	assign reg_rdata_o          = rdata_reg;
	assign mode_o               = mode_reg;
	assign fast_core_clock_en_o = clk_kept_reg;
	assign crossbar_block_o     = xbar_blk_reg;
	assign debug_capture_en_o   = capt_reg;
	assign debug_reset_o        = dbg_rst_reg;
	assign sys_reset_hold_o     = hold_reg;
	assign mass_erase_o         = erase_reg;
	assign secured_o            = secured_reg;
endmodule // dlpg_gate

/* File: design/dlpg_pkg.sv */
package dlpg_pkg;
	// Register word indices on the plain register port
	localparam logic [3:0] ADDR_STATUS  = 4'h0; // Access port status
	localparam logic [3:0] ADDR_CONTROL = 4'h1; // Access port control
	localparam logic [3:0] ADDR_MODE    = 4'h2; // Current power mode

	// Status register bit positions
	localparam int ST_ERASE_ACK   = 0;  // Mass erase request accepted
	localparam int ST_ERASE_BUSY  = 1;  // Mass erase in progress
	localparam int ST_SECURE      = 2;  // Device secured
	localparam int ST_ERASE_EN    = 3;  // Mass erase allowed
	localparam int ST_PSEUDO_STOP = 4;  // Stop substituted for deep stop
	localparam int ST_CLK_KEPT    = 5;  // Fast core clock held for debug
	localparam int ST_VLP         = 8;  // Very low power run or wait active
	localparam int ST_LEAK_EXIT   = 9;  // Leakage stop exit seen
	localparam int ST_VLEAK_EXIT  = 10; // Very leakage stop exit seen
	localparam int ST_CORE_HALTED = 16; // Core in debug halt
	localparam int ST_SLEEPDEEP   = 17; // Deep sleep indication
	localparam int ST_SLEEPING    = 18; // Sleeping indication

	// Control register bit positions
	localparam int CT_ERASE_REQ   = 0;  // Start mass erase
	localparam int CT_STAT_ACK    = 1;  // Acknowledge exit flags
	localparam int CT_HOLD_RESET  = 2;  // Hold system in reset on very leakage recovery
	localparam int CT_DEBUG_EN    = 3;  // Debug enabled
	localparam int CT_WIDTH       = 4;  // Stored control bits

	// Security field encodings
	localparam logic [1:0] SEC_UNSECURE = 2'h2; // Only unsecure code
	localparam logic [1:0] ERASE_OFF    = 2'h2; // Mass erase disabled

	// Mass erase duration in system clocks
	localparam logic [7:0] ERASE_CYCLES = 8'h10;

	// Power mode encoding on the mode request and mode outputs
	typedef enum logic [2:0] {
		PM_RUN        = 3'h0,
		PM_VLP_RUN    = 3'h1,
		PM_WAIT       = 3'h2,
		PM_VLP_WAIT   = 3'h3,
		PM_STOP       = 3'h4,
		PM_VLP_STOP   = 3'h5,
		PM_LEAK_STOP  = 3'h6,
		PM_VLEAK_STOP = 3'h7
	} dlpg_mode_t;
endpackage

/* File: design/dlpg_sync.sv */
`timescale 1ns/1ps
// Two flop synchroniser for a vector of level inputs
module dlpg_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_sys_i,
	input  wire logic         rst_n_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] s1_reg; // First stage, read only by second
	logic [W-1:0] s2_reg; // Second stage
	logic [W-1:0] s1_next;
	logic [W-1:0] s2_next;

	// Next values
	always_comb begin
		s1_next = d_i;
		s2_next = s1_reg;
	end

	// Registers
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_reg <= '0;
			s2_reg <= '0;
		end else begin
			s1_reg <= s1_next;
			s2_reg <= s2_next;
		end
	end

	assign q_o = s2_reg;
endmodule // dlpg_sync

/* File: tb/dlpg_gate_sva.sv */
`timescale 1ns/1ps
// Port checks for the debug power and security gate
module dlpg_gate_sva (
	input wire logic        clk_sys_i,
	input wire logic        arst_n_i,
	input wire logic [3:0]  reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic        reg_wr_i,
	input wire logic        reg_rd_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic        dbg_pwrup_req_i,
	input wire logic [1:0]  security_state_i,
	input wire logic [1:0]  mass_erase_enable_i,
	input wire logic [2:0]  mode_o,
	input wire logic        fast_core_clock_en_o,
	input wire logic        crossbar_block_o,
	input wire logic        debug_capture_en_o,
	input wire logic        mass_erase_o,
	input wire logic        secured_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!arst_n_i);
	// Long windows allow for the reset and request synchronisers
	a_secure_set: assert property ((security_state_i != 2'h2)[*8] |->
		secured_o) else $error("secured flag missing");
	a_secure_clr: assert property ((security_state_i == 2'h2)[*8] |->
		!secured_o) else $error("secured flag stuck");
	a_deep_demote: assert property (dbg_pwrup_req_i[*8] |->
		mode_o != dlpg_pkg::PM_VLP_STOP) else $error("deep stop kept");
	a_clock_kept: assert property (dbg_pwrup_req_i[*8] ##0
		(mode_o == dlpg_pkg::PM_STOP)[*3] |-> fast_core_clock_en_o)
		else $error("fast clock stopped");
	a_crossbar_cut: assert property ((mode_o == dlpg_pkg::PM_STOP &&
		fast_core_clock_en_o)[*2] |-> crossbar_block_o)
		else $error("crossbar open");
	a_capture_off: assert property ((mode_o >= dlpg_pkg::PM_LEAK_STOP)[*2]
		|-> !debug_capture_en_o) else $error("capture in leak");
	a_erase_block: assert property ((secured_o &&
		mass_erase_enable_i == 2'h2)[*3] |-> !$rose(mass_erase_o))
		else $error("erase not blocked");
	a_erase_start: assert property (reg_wr_i && reg_addr_i == 4'h1 &&
		reg_wdata_i[0] && secured_o && mass_erase_enable_i != 2'h2
		|-> ##[1:4] mass_erase_o) else $error("erase not started");
	a_status_read: assert property (reg_rd_i && reg_addr_i == 4'h0 &&
		$stable(secured_o) |=> reg_rdata_o[2] == $past(secured_o))
		else $error("status secure bit wrong");
	c_kept: cover property (mode_o == dlpg_pkg::PM_STOP &&
		fast_core_clock_en_o);
	c_erase: cover property ($rose(mass_erase_o));
	c_deep: cover property (mode_o == dlpg_pkg::PM_VLP_STOP);
endmodule // dlpg_gate_sva
bind dlpg_gate dlpg_gate_sva u_dlpg_gate_sva (.clk_sys_i, .arst_n_i,
	.reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
	.dbg_pwrup_req_i, .security_state_i, .mass_erase_enable_i, .mode_o,
	.fast_core_clock_en_o, .crossbar_block_o, .debug_capture_en_o,
	.mass_erase_o, .secured_o);

/* File: tb/dlpg_probe.sv */
`timescale 1ns/1ps
// Debugger probe: holds the two power-up requests of a session
module dlpg_probe (
	input  wire logic       clk_sys_i,
	input  wire logic [2:0] mode_i,   // Mode the device reports
	input  wire logic       want_i,   // Bench asks for a session
	output logic            dbg_o,    // Debug power-up request
	output logic            sys_o     // System power-up request
);
	logic ok; // Mode in which requests may move
	assign ok = mode_i inside {dlpg_pkg::PM_RUN, dlpg_pkg::PM_VLP_RUN,
		dlpg_pkg::PM_WAIT, dlpg_pkg::PM_VLP_WAIT};
	logic in_leak;   // Previous cycle was leakage stop
	logic link_rst;  // Two-wire link controller reset pulse
	initial begin
		dbg_o = 1'b0;
		sys_o = 1'b0;
		in_leak = 1'b0;
		link_rst = 1'b0;
	end
	// Two-wire link controller is reset on leaving leakage stop
	always @(posedge clk_sys_i) begin
		in_leak <= (mode_i == dlpg_pkg::PM_LEAK_STOP);
		link_rst <= in_leak && (mode_i != dlpg_pkg::PM_LEAK_STOP);
	end
	// Requests frozen in stop modes, as a real probe would see them
	always @(posedge clk_sys_i) begin
		if (ok) begin
			dbg_o <= want_i;
			sys_o <= want_i;
		end
	end
endmodule // dlpg_probe

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	logic clk_sys_i, arst_n_i, reg_wr_i, reg_rd_i, recovery_i, core_halted_i;
	logic dbg_pwrup_req_i, sys_pwrup_req_i, want, seen;
	logic [3:0]  reg_addr_i;
	logic [31:0] reg_wdata_i, reg_rdata_o, d;
	logic [2:0]  mode_req_i, mode_o;
	logic [1:0]  security_state_i, mass_erase_enable_i;
	logic fast_core_clock_en_o, crossbar_block_o, debug_capture_en_o;
	logic debug_reset_o, sys_reset_hold_o, mass_erase_o, secured_o;
	int n_fail = 0;
	int compares = 0;
	dlpg_gate u_dlpg_gate (.clk_sys_i, .arst_n_i, .reg_addr_i, .reg_wdata_i,
		.reg_wr_i, .reg_rd_i, .reg_rdata_o, .dbg_pwrup_req_i,
		.sys_pwrup_req_i, .mode_req_i, .recovery_i, .security_state_i,
		.mass_erase_enable_i, .core_halted_i, .mode_o, .fast_core_clock_en_o,
		.crossbar_block_o, .debug_capture_en_o, .debug_reset_o,
		.sys_reset_hold_o, .mass_erase_o, .secured_o);
	dlpg_probe u_dlpg_probe (.clk_sys_i, .mode_i(mode_o), .want_i(want),
		.dbg_o(dbg_pwrup_req_i), .sys_o(sys_pwrup_req_i));
	// 40 MHz system clock
	initial begin
		clk_sys_i = 1'b0;
		forever #12.5 clk_sys_i = ~clk_sys_i;
	end
	// Catch any debug reset pulse, which may be short
	always @(posedge clk_sys_i) if (debug_reset_o === 1'b1) seen <= 1'b1;
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		reg_addr_i <= a;
		reg_wdata_i <= v;
		reg_wr_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
	endtask
	// Data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
		#1 d = reg_rdata_o;
		@(posedge clk_sys_i);
	endtask
	task automatic chk1(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t flag %b not %b", $time, got, exp);
		end
	endtask
	task automatic chk3(input logic [2:0] got, input logic [2:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t mode %h not %h", $time, got, exp);
		end
	endtask
	task automatic t_secure();
		security_state_i <= 2'h1;
		tick(10);
		chk1(secured_o, 1'b1);
		rd(dlpg_pkg::ADDR_STATUS);
		chk1(d[dlpg_pkg::ST_SECURE], 1'b1);
		rd(4'hF);
		chk1(|d, 1'b0);
		mass_erase_enable_i <= 2'h2;
		wr(dlpg_pkg::ADDR_CONTROL, 32'h1);
		tick(6);
		chk1(mass_erase_o, 1'b0);
		mass_erase_enable_i <= 2'h0;
		wr(dlpg_pkg::ADDR_CONTROL, 32'h1);
		tick(3);
		chk1(mass_erase_o, 1'b1);
		tick(20);
		chk1(mass_erase_o, 1'b0);
		security_state_i <= 2'h2;
		tick(10);
		chk1(secured_o, 1'b0);
	endtask
	// Deep stop with and without a debugger, via very low power run
	task automatic t_stop(input logic dbg);
		want <= dbg;
		core_halted_i <= dbg;
		wr(dlpg_pkg::ADDR_CONTROL, {28'h0, dbg, 3'h0});
		tick(8);
		mode_req_i <= dlpg_pkg::PM_VLP_RUN;
		tick(8);
		mode_req_i <= dlpg_pkg::PM_VLP_STOP;
		tick(10);
		chk3(mode_o, dbg ? dlpg_pkg::PM_STOP : dlpg_pkg::PM_VLP_STOP);
		chk1(fast_core_clock_en_o, dbg);
		chk1(crossbar_block_o, dbg);
		rd(dlpg_pkg::ADDR_STATUS);
		chk1(d[dlpg_pkg::ST_PSEUDO_STOP], dbg);
		chk1(d[dlpg_pkg::ST_CORE_HALTED], dbg);
		mode_req_i <= dlpg_pkg::PM_RUN;
		tick(10);
	endtask
	// Leakage stop then recovery; hold bit armed in both, reset held only after the very leaky one
	task automatic t_leak(input logic [2:0] m, input int bit_no);
		seen <= 1'b0;
		wr(dlpg_pkg::ADDR_CONTROL, 32'h4);
		mode_req_i <= m;
		tick(8);
		chk1(debug_capture_en_o, 1'b0);
		mode_req_i <= dlpg_pkg::PM_RUN;
		recovery_i <= 1'b1;
		tick(2);
		recovery_i <= 1'b0;
		tick(6);
		chk1(seen, m == dlpg_pkg::PM_VLEAK_STOP);
		chk1(sys_reset_hold_o, m == dlpg_pkg::PM_VLEAK_STOP);
		rd(dlpg_pkg::ADDR_STATUS);
		chk1(d[bit_no], 1'b1);
		wr(dlpg_pkg::ADDR_CONTROL, 32'h2);
		rd(dlpg_pkg::ADDR_STATUS);
		chk1(d[bit_no], 1'b0);
	endtask
	task automatic test_done();
		if (n_fail == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		{arst_n_i, reg_wr_i, reg_rd_i, recovery_i, core_halted_i} = '0;
		{want, seen, reg_addr_i, reg_wdata_i, mass_erase_enable_i} = '0;
		mode_req_i = dlpg_pkg::PM_RUN;
		security_state_i = 2'h2;
		tick(16);
		arst_n_i <= 1'b1;
		tick(4);
		t_secure();
		t_stop(1'b1);
		t_stop(1'b0);
		t_leak(dlpg_pkg::PM_LEAK_STOP, dlpg_pkg::ST_LEAK_EXIT);
		t_leak(dlpg_pkg::PM_VLEAK_STOP, dlpg_pkg::ST_VLEAK_EXIT);
		test_done();
	end
	// Watchdog well past the few hundred cycles of the sequence
	initial begin
		#200000;
		n_fail++;
		test_done();
	end
endmodule // tb_top
